// File: hw/mlgreg_pkg.sv
package mlgreg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 32;
  localparam int REG_W       = 16;
  localparam int N_MUX_LANES = 10;
  localparam int N_GB_LANES  = 20;
  localparam int N_RX_LANES  = 4;
  localparam int CNT_W       = 32;
  localparam int MEM_AW      = 5;
  localparam int MEM_DEPTH   = 32;
  localparam int MAP_W       = 8;
  localparam int MANT_W      = 10;
  localparam int EXP_W       = 6;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_GEN_CTRL        = 16'hA080;
  localparam logic [15:0] IDX_MUX_LANE_EN     = 16'hA081;
  localparam logic [15:0] IDX_MUX_TIMING_REF  = 16'hA082;
  localparam logic [15:0] IDX_MUX_IDLE_EN     = 16'hA083;
  localparam logic [15:0] IDX_MUX_STATUS      = 16'hA088;
  localparam logic [15:0] IDX_DMX_LANE_EN     = 16'hA090;
  localparam logic [15:0] IDX_DMX_IDLE_CHK_EN = 16'hA091;
  localparam logic [15:0] IDX_DMX_STATUS      = 16'hA098;
  localparam logic [15:0] IDX_BLK_LOCK_UPPER  = 16'hA099;
  localparam logic [15:0] IDX_BLK_LOCK_LOWER  = 16'hA09A;
  localparam logic [15:0] IDX_MRK_LOCK_UPPER  = 16'hA09B;
  localparam logic [15:0] IDX_MRK_LOCK_LOWER  = 16'hA09C;
  localparam logic [15:0] IDX_ALIGN_UPPER     = 16'hA09D;
  localparam logic [15:0] IDX_ALIGN_LOWER     = 16'hA09E;
  localparam logic [15:0] IDX_PARITY_FIRST    = 16'hA0A0;
  localparam logic [15:0] IDX_PARITY_LAST     = 16'hA0B3;
  localparam logic [15:0] IDX_MAP_FIRST       = 16'hA0C0;
  localparam logic [15:0] IDX_MAP_LAST        = 16'hA0D3;
  localparam logic [15:0] IDX_IDLE_ERR_FIRST  = 16'hA0E0;
  localparam logic [15:0] IDX_IDLE_ERR_LAST   = 16'hA0E9;

  // ----------------------------------------------------------------
  // Fields, masks and reset values
  // ----------------------------------------------------------------
  localparam int          GEN_MUX_EN_BIT    = 15;
  localparam int          GEN_DMX_EN_BIT    = 14;
  localparam int          STAT_IDLE_ABLE_BIT = 15;
  localparam logic [15:0] GEN_CTRL_MASK     = 16'hC3FF;
  localparam logic [15:0] LANE10_MASK       = 16'h03FF;
  localparam logic [15:0] TIMING_REF_MASK   = 16'h000F;
  localparam logic [15:0] REG_RESET         = 16'h0000;
  localparam logic [4:0]  MEM_PARITY_LAST   = 5'h13;
  localparam logic [4:0]  MEM_IDLE_LAST     = 5'h1D;
  localparam logic [4:0]  MEM_SCAN_LAST     = 5'h1D;
  localparam logic [1:0]  AXI_RESP_OKAY     = 2'h0;

  typedef enum logic [2:0] {
    MLGREG_RD_IDLE  = 3'b001,
    MLGREG_RD_FETCH = 3'b010,
    MLGREG_RD_RESP  = 3'b100
  } mlgreg_rd_state_t;

endpackage : mlgreg_pkg

// File: hw/mlgreg_count_mem.sv
`timescale 1ns/1ps
module mlgreg_count_mem
  import mlgreg_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              wr_en,
  input  wire logic [MEM_AW-1:0] wr_addr,
  input  wire logic [CNT_W-1:0]  wr_data,
  input  wire logic [MEM_AW-1:0] rd_a_addr,
  output logic      [CNT_W-1:0]  rd_a_data,
  input  wire logic [MEM_AW-1:0] rd_b_addr,
  output logic      [CNT_W-1:0]  rd_b_data
);

  logic [CNT_W-1:0] mem [MEM_DEPTH];

  // Contents are not reset; the owner clears entries 0..29 after reset
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    rd_a_data <= mem[rd_a_addr];
    rd_b_data <= mem[rd_b_addr];
  end

endmodule : mlgreg_count_mem

// File: hw/mlgreg_bank.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
// Operation
// - General control bit 15 enables mux, bit 14 enables demux.
// - General control bits 9..0 enable loopback on the matching lane.
// - Mux lane enable bits 9..0 read-write, reset zero, upper bits reserved.
// - Mux timing reference bits 3..0 pick timing lane 0..9; others undefined.
// - Mux idle enable bits 9..0 turn on idle pattern generation per lane.
// - Mux status bit 15 reports idle pattern generation ability.
// - Mux status lane bit set only with clock recovery and block lock.
// - Demux lane enable bits 9..0 enable each output lane.
// - Demux idle check bits 9..0 enable the idle checker per lane.
// - Demux status bit 15 idle ability, bits 3..0 lanes received.
// - Block lock: upper register lanes 19..16, lower register lanes 15..0.
// - Marker lock reported with the same two-register split.
// - Alignment reports marker lock, distinct markers and tolerable skew.
// - Twenty read-only parity error counts, 6-bit exponent, 10-bit mantissa.
// - Parity counts in reverse lane order, lowest address lane 19.
// - Twenty mapping registers report logical lane x.y, reverse lane order.
// - Ten idle error registers, first address lane 9, last lane 0.
// - Count format uses base-2 exponent and integer mantissa.
// - Exponent in bits 15..10, mantissa in bits 9..0.
module mlgreg_bank
  import mlgreg_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [DATA_W-1:0]           s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [DATA_W-1:0]                s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Gearbox controls
  output logic                             multi_link_gearbox_mux_enable,
  output logic                             multi_link_gearbox_demux_enable,
  output logic [N_MUX_LANES-1:0]           loopback_enable,
  output logic [N_MUX_LANES-1:0]           mux_lane_enable,
  output logic [3:0]                       mux_timing_lane,
  output logic [N_MUX_LANES-1:0]           mux_idle_gen_enable,
  output logic [N_MUX_LANES-1:0]           demux_lane_enable,
  output logic [N_MUX_LANES-1:0]           demux_idle_check_enable,
  // Gearbox status
  input  wire logic                        idle_gen_able,
  input  wire logic                        idle_check_able,
  input  wire logic [N_MUX_LANES-1:0]      clock_recovery_lock,
  input  wire logic [N_MUX_LANES-1:0]      mux_block_lock,
  input  wire logic [N_RX_LANES-1:0]       demux_lane_received,
  input  wire logic [N_GB_LANES-1:0]       demux_block_lock,
  input  wire logic [N_GB_LANES-1:0]       alignment_marker_lock,
  input  wire logic                        markers_distinct,
  input  wire logic                        skew_ok,
  input  wire logic [N_GB_LANES*MAP_W-1:0] logical_lane_map,
  input  wire logic [N_GB_LANES-1:0]       interleaved_parity_error,
  input  wire logic [N_MUX_LANES-1:0]      idle_pattern_error
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [REG_W-1:0] gen_ctrl;
  logic [REG_W-1:0] mux_lane_en_reg;
  logic [REG_W-1:0] mux_timing_reg;
  logic [REG_W-1:0] mux_idle_en_reg;
  logic [REG_W-1:0] dmx_lane_en_reg;
  logic [REG_W-1:0] dmx_idle_chk_reg;

  // Write channel
  logic              aw_held;
  logic              w_held;
  logic [15:0]       wr_idx;
  logic [REG_W-1:0]  wr_val;
  logic [1:0]        wr_strb;
  logic              do_write;
  logic [REG_W-1:0]  wr_bytemask;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = AXI_RESP_OKAY;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_bytemask   = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_idx  <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_idx  <= s_axi_awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wr_val  <= REG_RESET;
      wr_strb <= 2'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      wr_val  <= s_axi_wdata[REG_W-1:0];
      wr_strb <= s_axi_wstrb[1:0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v, input logic [REG_W-1:0] new_v,
                                             input logic [REG_W-1:0] bmask, input logic [REG_W-1:0] fmask);
    merge = ((old_v & ~bmask) | (new_v & bmask)) & fmask;
  endfunction : merge

  // Reserved bits are masked off on every write, so they always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_ctrl         <= REG_RESET;
      mux_lane_en_reg  <= REG_RESET;
      mux_timing_reg   <= REG_RESET;
      mux_idle_en_reg  <= REG_RESET;
      dmx_lane_en_reg  <= REG_RESET;
      dmx_idle_chk_reg <= REG_RESET;
    end else if (do_write) begin
      unique case (wr_idx)
        IDX_GEN_CTRL:        gen_ctrl         <= merge(gen_ctrl, wr_val, wr_bytemask, GEN_CTRL_MASK);
        IDX_MUX_LANE_EN:     mux_lane_en_reg  <= merge(mux_lane_en_reg, wr_val, wr_bytemask, LANE10_MASK);
        IDX_MUX_TIMING_REF:  mux_timing_reg   <= merge(mux_timing_reg, wr_val, wr_bytemask, TIMING_REF_MASK);
        IDX_MUX_IDLE_EN:     mux_idle_en_reg  <= merge(mux_idle_en_reg, wr_val, wr_bytemask, LANE10_MASK);
        IDX_DMX_LANE_EN:     dmx_lane_en_reg  <= merge(dmx_lane_en_reg, wr_val, wr_bytemask, LANE10_MASK);
        IDX_DMX_IDLE_CHK_EN: dmx_idle_chk_reg <= merge(dmx_idle_chk_reg, wr_val, wr_bytemask, LANE10_MASK);
        default: begin
          // Writes elsewhere are dropped
        end
      endcase
    end
  end

  assign multi_link_gearbox_mux_enable   = gen_ctrl[GEN_MUX_EN_BIT];
  assign multi_link_gearbox_demux_enable = gen_ctrl[GEN_DMX_EN_BIT];
  assign loopback_enable                 = gen_ctrl[N_MUX_LANES-1:0];
  assign mux_lane_enable                 = mux_lane_en_reg[N_MUX_LANES-1:0];
  // Codes above 9 are held as written; the datapath treats them as undefined
  assign mux_timing_lane                 = mux_timing_reg[3:0];
  assign mux_idle_gen_enable             = mux_idle_en_reg[N_MUX_LANES-1:0];
  assign demux_lane_enable               = dmx_lane_en_reg[N_MUX_LANES-1:0];
  // With no checker present the enables are held but never acted on
  assign demux_idle_check_enable         = dmx_idle_chk_reg[N_MUX_LANES-1:0] & {N_MUX_LANES{idle_check_able}};

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // Entries 0..19 hold parity counts of lanes 0..19, entries 20..29 idle
  // errors of lanes 0..9. A scanner visits each entry once every 30 cycles,
  // so several events on one lane inside a visit merge into one count.
  logic [N_GB_LANES+N_MUX_LANES-1:0] pend;
  logic [N_GB_LANES+N_MUX_LANES-1:0] event_in;
  logic [MEM_AW-1:0]                 scan_idx;
  logic [MEM_AW-1:0]                 scan_prev;
  logic                              scan_valid;
  logic                              clr_active;
  logic                              cnt_wr_en;
  logic [CNT_W-1:0]                  cnt_wr_data;
  logic [CNT_W-1:0]                  scan_data;
  logic [CNT_W-1:0]                  bus_cnt_data;
  logic [MEM_AW-1:0]                 bus_cnt_addr;

  // Parity errors count only while the demux runs; idle errors only while checked
  assign event_in = {idle_pattern_error & demux_idle_check_enable,
                     interleaved_parity_error & {N_GB_LANES{multi_link_gearbox_demux_enable}}};

  assign cnt_wr_en   = scan_valid && (clr_active || pend[scan_prev]);
  assign cnt_wr_data = clr_active ? {CNT_W{1'b0}} :
                       ((&scan_data) ? scan_data : scan_data + 32'h0000_0001);

  genvar g;
  generate
    for (g = 0; g < N_GB_LANES + N_MUX_LANES; g++) begin : g_pend
      // A new event wins over the clear of its own pending flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pend[g] <= 1'b0;
        end else if (event_in[g]) begin
          pend[g] <= 1'b1;
        end else if (cnt_wr_en && !clr_active && scan_prev == MEM_AW'(g)) begin
          pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_idx   <= 5'h00;
      scan_prev  <= 5'h00;
      scan_valid <= 1'b0;
    end else begin
      scan_idx   <= (scan_idx == MEM_SCAN_LAST) ? 5'h00 : scan_idx + 5'h01;
      scan_prev  <= scan_idx;
      scan_valid <= 1'b1;
    end
  end

  // First pass after reset zeroes entries 0..29; entries 30 and 31 are never written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_active <= 1'b1;
    end else if (scan_valid && scan_prev == MEM_SCAN_LAST) begin
      clr_active <= 1'b0;
    end
  end

  mlgreg_count_mem u_count_mem (
    .aclk      (aclk),
    .wr_en     (cnt_wr_en),
    .wr_addr   (scan_prev),
    .wr_data   (cnt_wr_data),
    .rd_a_addr (scan_idx),
    .rd_a_data (scan_data),
    .rd_b_addr (bus_cnt_addr),
    .rd_b_data (bus_cnt_data)
  );

  // Raw count to exponent and mantissa, value = mantissa * 2**exponent
  function automatic logic [REG_W-1:0] to_float(input logic [CNT_W-1:0] cnt);
    logic [5:0]       msb;
    logic [EXP_W-1:0] ex;
    logic [CNT_W-1:0] shifted;
    msb = 6'h00;
    for (int i = 0; i < CNT_W; i++) begin
      if (cnt[i]) begin
        msb = 6'(i);
      end
    end
    ex      = (msb > 6'h09) ? msb - 6'h09 : 6'h00;
    shifted = cnt >> ex;
    to_float = {ex, shifted[MANT_W-1:0]};
  endfunction : to_float

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  mlgreg_rd_state_t rd_state;
  logic [15:0]      rd_idx;
  logic [15:0]      ar_idx;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] rd_live;
  logic [N_GB_LANES-1:0] aligned;
  logic [15:0]      par_off;
  logic [15:0]      idle_off;
  logic [15:0]      map_off;
  logic [4:0]       map_lane;

  assign s_axi_arready = (rd_state == MLGREG_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == MLGREG_RD_RESP);
  assign s_axi_rresp   = AXI_RESP_OKAY;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];
  assign par_off       = ar_idx - IDX_PARITY_FIRST;
  assign idle_off      = ar_idx - IDX_IDLE_ERR_FIRST;
  assign map_off       = rd_idx - IDX_MAP_FIRST;
  assign map_lane      = MEM_PARITY_LAST - map_off[4:0];

  // Counter entry is fetched during the address handshake
  always_comb begin
    if (ar_idx >= IDX_IDLE_ERR_FIRST && ar_idx <= IDX_IDLE_ERR_LAST) begin
      bus_cnt_addr = MEM_IDLE_LAST - idle_off[4:0];
    end else begin
      bus_cnt_addr = MEM_PARITY_LAST - par_off[4:0];
    end
  end

  // A lane counts as aligned when locked, markers distinct and skew tolerable
  assign aligned = alignment_marker_lock & {N_GB_LANES{markers_distinct && skew_ok}};

  always_comb begin
    rd_live = REG_RESET;
    unique case (rd_idx)
      IDX_GEN_CTRL:        rd_live = gen_ctrl;
      IDX_MUX_LANE_EN:     rd_live = mux_lane_en_reg;
      IDX_MUX_TIMING_REF:  rd_live = mux_timing_reg;
      IDX_MUX_IDLE_EN:     rd_live = mux_idle_en_reg;
      IDX_MUX_STATUS: begin
        rd_live[STAT_IDLE_ABLE_BIT]  = idle_gen_able;
        rd_live[N_MUX_LANES-1:0]     = clock_recovery_lock & mux_block_lock;
      end
      IDX_DMX_LANE_EN:     rd_live = dmx_lane_en_reg;
      IDX_DMX_IDLE_CHK_EN: rd_live = dmx_idle_chk_reg;
      IDX_DMX_STATUS: begin
        rd_live[STAT_IDLE_ABLE_BIT]  = idle_gen_able;
        rd_live[N_RX_LANES-1:0]      = demux_lane_received;
      end
      IDX_BLK_LOCK_UPPER:  rd_live[3:0] = demux_block_lock[N_GB_LANES-1:16];
      IDX_BLK_LOCK_LOWER:  rd_live      = demux_block_lock[15:0];
      IDX_MRK_LOCK_UPPER:  rd_live[3:0] = alignment_marker_lock[N_GB_LANES-1:16];
      IDX_MRK_LOCK_LOWER:  rd_live      = alignment_marker_lock[15:0];
      IDX_ALIGN_UPPER:     rd_live[3:0] = aligned[N_GB_LANES-1:16];
      IDX_ALIGN_LOWER:     rd_live      = aligned[15:0];
      default: begin
        if (rd_idx >= IDX_PARITY_FIRST && rd_idx <= IDX_PARITY_LAST) begin
          rd_live = to_float(bus_cnt_data);
        end else if (rd_idx >= IDX_IDLE_ERR_FIRST && rd_idx <= IDX_IDLE_ERR_LAST) begin
          rd_live = to_float(bus_cnt_data);
        end else if (rd_idx >= IDX_MAP_FIRST && rd_idx <= IDX_MAP_LAST) begin
          rd_live[MAP_W-1:0] = logical_lane_map[map_lane*MAP_W +: MAP_W];
        end else begin
          rd_live = REG_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= MLGREG_RD_IDLE;
      rd_idx   <= 16'h0000;
    end else begin
      unique case (rd_state)
        MLGREG_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_idx   <= ar_idx;
            rd_state <= MLGREG_RD_FETCH;
          end
        end
        MLGREG_RD_FETCH: begin
          rd_state <= MLGREG_RD_RESP;
        end
        MLGREG_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state <= MLGREG_RD_IDLE;
          end
        end
      endcase
    end
  end

  // Value is sampled once and held stable while rvalid waits for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_val <= REG_RESET;
    end else if (rd_state == MLGREG_RD_FETCH) begin
      rd_val <= rd_live;
    end
  end

  assign s_axi_rdata = {16'h0000, rd_val};

endmodule : mlgreg_bank

// File: verification/mlgreg_assertions.sv
`timescale 1ns/1ps
module mlgreg_assertions
  import mlgreg_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [DATA_W-1:0]      s_axi_rdata,
  input wire logic                   s_axi_bvalid,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   multi_link_gearbox_mux_enable,
  input wire logic                   multi_link_gearbox_demux_enable,
  input wire logic [N_MUX_LANES-1:0] loopback_enable,
  input wire logic [N_MUX_LANES-1:0] mux_lane_enable,
  input wire logic [3:0]             mux_timing_lane,
  input wire logic [N_MUX_LANES-1:0] mux_idle_gen_enable,
  input wire logic [N_MUX_LANES-1:0] demux_lane_enable,
  input wire logic [N_MUX_LANES-1:0] demux_idle_check_enable,
  input wire logic                   idle_check_able
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Controls other than demux_idle_check_enable move only at a completed write
  // ------------------------------------------------------------
  dir_en_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable({multi_link_gearbox_mux_enable,
    multi_link_gearbox_demux_enable})) else $error("direction enable changed without a write");
  loop_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(loopback_enable))
    else $error("loopback changed without a write");
  lane_en_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(mux_lane_enable))
    else $error("mux lane enable changed without a write");
  mux_cfg_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable({mux_timing_lane, mux_idle_gen_enable}))
    else $error("mux timing or idle enable changed without a write");
  dmx_en_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(demux_lane_enable))
    else $error("demux lane enable changed without a write");
  idle_gate_a: assert property (!idle_check_able |-> demux_idle_check_enable == 10'h000)
    else $error("idle checker enabled without the checker");
  // ------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rd_timing_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer late or read address taken twice");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  wr_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == AXI_RESP_OKAY)
    else $error("write response not okay");
  wr_done_c: cover property ($rose(s_axi_bvalid));
  rd_done_c: cover property (s_axi_rvalid && s_axi_rready);
  gated_c: cover property (idle_check_able && demux_idle_check_enable != 10'h000);
endmodule : mlgreg_assertions

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import mlgreg_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, multi_link_gearbox_mux_enable, multi_link_gearbox_demux_enable;
  logic idle_gen_able = 1'b0, idle_check_able = 1'b0, markers_distinct = 1'b0, skew_ok = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, mux_timing_lane, demux_lane_received = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [N_MUX_LANES-1:0] loopback_enable, mux_lane_enable, mux_idle_gen_enable, demux_lane_enable;
  logic [N_MUX_LANES-1:0] demux_idle_check_enable, clock_recovery_lock = '0, mux_block_lock = '0;
  logic [N_MUX_LANES-1:0] idle_pattern_error = '0;
  logic [N_GB_LANES-1:0] demux_block_lock = '0, alignment_marker_lock = '0, interleaved_parity_error = '0;
  logic [N_GB_LANES*MAP_W-1:0] logical_lane_map = '0;
  logic [15:0] rw_idx[6] = '{IDX_GEN_CTRL, IDX_MUX_LANE_EN, IDX_MUX_TIMING_REF, IDX_MUX_IDLE_EN,
                             IDX_DMX_LANE_EN, IDX_DMX_IDLE_CHK_EN};
  logic [15:0] rw_mask[6] = '{16'hC3FF, 16'h03FF, 16'h000F, 16'h03FF, 16'h03FF, 16'h03FF};
  int n_fail = 0, checked = 0, cyc = 0;

  mlgreg_bank uut (.*);

  initial begin
    forever #10 aclk = ~aclk;
  end
  // Hang guard: the counting scenario alone needs about 36k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("write resp", 32'h0, s_axi_bresp);
  endtask : wr
  task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(nm, exp, s_axi_rdata);
    chk("read resp", 32'h0, s_axi_rresp);
  endtask : rchk
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    foreach (rw_idx[i]) rchk("reset value", rw_idx[i], 32'h0);
    foreach (rw_idx[i]) begin
      wr(rw_idx[i], 32'hFFFFFFFF);
      rchk("reserved bits", rw_idx[i], {16'h0, rw_mask[i]});
    end
    chk("idle check gated", 32'h0, demux_idle_check_enable);
    wr(IDX_GEN_CTRL, 32'h4201);
    chk("directions", 32'h1, {multi_link_gearbox_mux_enable, multi_link_gearbox_demux_enable});
    chk("loopback", 32'h201, loopback_enable);
    wr(IDX_MUX_LANE_EN, 32'h155);
    chk("mux lanes", 32'h155, mux_lane_enable);
    s_axi_wstrb <= 4'h1;
    wr(IDX_MUX_LANE_EN, 32'h3FF);
    s_axi_wstrb <= 4'hF;
    rchk("low byte strobe", IDX_MUX_LANE_EN, 32'h1FF);
    wr(IDX_MUX_TIMING_REF, 32'h9);
    chk("timing lane", 32'h9, mux_timing_lane);
    wr(IDX_MUX_IDLE_EN, 32'h2AA);
    chk("idle gen", 32'h2AA, mux_idle_gen_enable);
    wr(IDX_DMX_LANE_EN, 32'h0AB);
    chk("demux lanes", 32'h0AB, demux_lane_enable);
    idle_check_able <= 1'b1;
    idle_gen_able <= 1'b1;
    clock_recovery_lock <= 10'h3F0;
    mux_block_lock <= 10'h0FF;
    demux_lane_received <= 4'hA;
    demux_block_lock <= 20'hA5A5A;
    alignment_marker_lock <= 20'h51234;
    markers_distinct <= 1'b1;
    skew_ok <= 1'b1;
    for (int n = 0; n < 20; n++) logical_lane_map[n*8 +: 8] <= {4'(n / 2), 4'(n % 2)};
    @(posedge aclk);
    chk("idle check on", 32'h3FF, demux_idle_check_enable);
    rchk("mux status", IDX_MUX_STATUS, 32'h80F0);
    rchk("demux status", IDX_DMX_STATUS, 32'h800A);
    rchk("block lock hi", IDX_BLK_LOCK_UPPER, 32'hA);
    rchk("block lock lo", IDX_BLK_LOCK_LOWER, 32'h5A5A);
    rchk("marker lock hi", IDX_MRK_LOCK_UPPER, 32'h5);
    rchk("marker lock lo", IDX_MRK_LOCK_LOWER, 32'h1234);
    rchk("align hi", IDX_ALIGN_UPPER, 32'h5);
    skew_ok <= 1'b0;
    rchk("align skewed", IDX_ALIGN_LOWER, 32'h0);
    for (int n = 0; n < 20; n++) rchk("lane map", IDX_MAP_FIRST + 16'(19 - n), {4'(n / 2), 4'(n % 2)});
    rchk("unmapped", 16'hA084, 32'h0);
    wr(IDX_MUX_STATUS, 32'hFFFF);
    rchk("read only", IDX_MUX_STATUS, 32'h80F0);
    // Events spaced past one scan so every pulse is counted
    for (int k = 0; k < 1100; k++) begin
      interleaved_parity_error <= (k == 0) ? 20'h80001 : 20'h00001;
      idle_pattern_error <= (k < 3) ? 10'h200 : 10'h000;
      @(posedge aclk);
      interleaved_parity_error <= '0;
      idle_pattern_error <= '0;
      repeat (32) @(posedge aclk);
    end
    rchk("parity lane 19", IDX_PARITY_FIRST, 32'h1);
    rchk("parity lane 0", IDX_PARITY_LAST, 32'h0626);
    rchk("idle err lane 9", IDX_IDLE_ERR_FIRST, 32'h3);
    rchk("idle err lane 0", IDX_IDLE_ERR_LAST, 32'h0);
    wr(IDX_GEN_CTRL, 32'h0);
    interleaved_parity_error <= 20'h00020;
    @(posedge aclk);
    interleaved_parity_error <= '0;
    repeat (34) @(posedge aclk);
    rchk("parity demux off", IDX_PARITY_FIRST + 16'd14, 32'h0);
    complete_run();
  end
endmodule : tb

bind mlgreg_bank mlgreg_assertions chk_i (.*);
